/* hdl/mic_pkg.sv */
// package: constants for the motion interrupt collector
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package mic_pkg;
    localparam int MIC_DATA_W = 16;
    localparam int MIC_ADDR_W = 4;
    localparam int MIC_HALF_W = 8;
    // register addresses on the host bus (word mode and byte halves)
    localparam logic [3:0] MIC_ADDR_ENABLE = 4'h2;
    localparam logic [3:0] MIC_ADDR_ENABLE_HI = 4'h3;
    localparam logic [3:0] MIC_ADDR_STATUS = 4'h2;
    localparam logic [3:0] MIC_ADDR_STATUS_HI = 4'h3;
    localparam logic [15:0] MIC_ENABLE_RST = 16'h0000;
    localparam logic [15:0] MIC_STATUS_RST = 16'h0000;
    // status bit positions
    localparam int MIC_BIT_CMP0 = 0;
    localparam int MIC_BIT_DRIVE_BEGIN = 4;
    localparam int MIC_BIT_CRUISE_BEGIN = 5;
    localparam int MIC_BIT_CRUISE_END = 6;
    localparam int MIC_BIT_DRIVE_END = 7;
    localparam int MIC_BIT_HOME_END = 8;
    localparam int MIC_BIT_TIMER = 9;
    localparam int MIC_BIT_SPLIT = 10;
    localparam int MIC_BIT_SPLIT_DONE = 11;
    localparam int MIC_BIT_LINK0 = 12;
endpackage

/* hdl/mic_status_bit.sv */
// one latched interrupt status bit with read-end clear
`timescale 1ns/1ps
module mic_status_bit (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic source_event,
    input wire logic source_enable,
    input wire logic clear_now,
    output logic pending
);
    logic next_pending;
    // set wins over the clear so an event in the clear cycle survives
    assign next_pending = (source_event && source_enable) ? 1'b1 :
                          (clear_now ? 1'b0 : pending);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pending <= 1'b0;
        end else begin
            pending <= next_pending;
        end
    end

    set_wins_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (source_event && source_enable) |=> pending)
        else $error("enabled event did not set status");
    masked_stays_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!source_enable && !pending) |=> !pending)
        else $error("masked source set status");
    clear_drop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (clear_now && !(source_event && source_enable)) |=> !pending)
        else $error("status survived its clear");
endmodule // mic_status_bit

/* hdl/mic_irq_collector.sv */
// interrupt collector: enable register, latched status, read-clear, open-drain output
`timescale 1ns/1ps
module mic_irq_collector (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [3:0] compare_hit,
    input wire logic drive_begin_event,
    input wire logic cruise_begin_event,
    input wire logic cruise_end_event,
    input wire logic drive_end_event,
    input wire logic home_end_event,
    input wire logic timer_expire_event,
    input wire logic split_pulse_event,
    input wire logic split_train_done_event,
    input wire logic linked_action_0_event,
    input wire logic linked_action_1_event,
    input wire logic linked_action_2_event,
    input wire logic linked_action_3_event,
    input wire logic bus_byte_mode,
    input wire logic [3:0] host_addr,
    input wire logic host_chip_sel_n,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic [15:0] host_wdata,
    output logic [15:0] host_rdata,
    output logic host_irq_out_n,
    output logic host_irq_oe
);
    // ------------------------------------------------------------------
    // event gathering
    // ------------------------------------------------------------------
    logic [15:0] source_vec;
    logic split_q;
    wire split_rise = split_pulse_event && !split_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            split_q <= 1'b0;
        end else begin
            split_q <= split_pulse_event;
        end
    end
    always_comb begin
        source_vec = mic_pkg::MIC_STATUS_RST;
        source_vec[mic_pkg::MIC_BIT_CMP0 +: 4] = compare_hit;
        source_vec[mic_pkg::MIC_BIT_DRIVE_BEGIN] = drive_begin_event;
        source_vec[mic_pkg::MIC_BIT_CRUISE_BEGIN] = cruise_begin_event;
        source_vec[mic_pkg::MIC_BIT_CRUISE_END] = cruise_end_event;
        source_vec[mic_pkg::MIC_BIT_DRIVE_END] = drive_end_event;
        source_vec[mic_pkg::MIC_BIT_HOME_END] = home_end_event;
        source_vec[mic_pkg::MIC_BIT_TIMER] = timer_expire_event;
        source_vec[mic_pkg::MIC_BIT_SPLIT] = split_rise;
        source_vec[mic_pkg::MIC_BIT_SPLIT_DONE] = split_train_done_event;
        source_vec[mic_pkg::MIC_BIT_LINK0 +: 4] = {linked_action_3_event,
            linked_action_2_event, linked_action_1_event, linked_action_0_event};
    end

    // ------------------------------------------------------------------
    // host bus decode
    // ------------------------------------------------------------------
    wire rd_act = !host_chip_sel_n && !host_read_strobe_n;
    wire wr_act = !host_chip_sel_n && !host_write_strobe_n;
    wire hit_lo = (host_addr == mic_pkg::MIC_ADDR_STATUS);
    wire hit_hi = bus_byte_mode && (host_addr == mic_pkg::MIC_ADDR_STATUS_HI);
    wire wr_lo = wr_act && (host_addr == mic_pkg::MIC_ADDR_ENABLE);
    wire wr_hi = wr_act && bus_byte_mode && (host_addr == mic_pkg::MIC_ADDR_ENABLE_HI);

    // ------------------------------------------------------------------
    // enable register, all masked at reset
    // ------------------------------------------------------------------
    logic [15:0] irq_source_enable;
    logic [15:0] next_enable;
    always_comb begin
        next_enable = irq_source_enable;
        if (wr_lo && !bus_byte_mode) begin
            next_enable = host_wdata;
        end else if (wr_lo) begin
            next_enable[mic_pkg::MIC_HALF_W-1:0] = host_wdata[mic_pkg::MIC_HALF_W-1:0];
        end else if (wr_hi) begin
            next_enable[15:mic_pkg::MIC_HALF_W] = host_wdata[mic_pkg::MIC_HALF_W-1:0];
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_source_enable <= mic_pkg::MIC_ENABLE_RST;
        end else begin
            irq_source_enable <= next_enable;
        end
    end

    // ------------------------------------------------------------------
    // read tracking: clear fires on the strobe's rising edge
    // ------------------------------------------------------------------
    // a stray decode during the low strobe arms the clear; host must hold address
    logic rd_lo_arm;
    logic rd_hi_arm;
    logic [15:0] irq_pending_status;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_lo_arm <= 1'b0;
            rd_hi_arm <= 1'b0;
        end else begin
            rd_lo_arm <= rd_act && hit_lo;
            rd_hi_arm <= rd_act && hit_hi;
        end
    end
    wire end_lo = rd_lo_arm && !(rd_act && hit_lo);
    wire end_hi = rd_hi_arm && !(rd_act && hit_hi);
    // only bits that went out on the bus are cleared: an event caught in the last
    // strobe-low cycle missed the returned data and stays pending for the next read
    wire [15:0] reported_lo = bus_byte_mode ?
        {{mic_pkg::MIC_HALF_W{1'b0}}, host_rdata[mic_pkg::MIC_HALF_W-1:0]} : host_rdata;
    wire [15:0] reported_hi =
        {host_rdata[mic_pkg::MIC_HALF_W-1:0], {mic_pkg::MIC_HALF_W{1'b0}}};
    logic [15:0] clear_vec;
    assign clear_vec = bus_byte_mode ?
        (({16{end_hi}} & reported_hi) | ({16{end_lo}} & reported_lo)) :
        ({16{end_lo}} & reported_lo);

    genvar gi;
    generate
        for (gi = 0; gi < mic_pkg::MIC_DATA_W; gi++) begin : g_bit
            mic_status_bit u_bit (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .source_event(source_vec[gi]),
                .source_enable(irq_source_enable[gi]),
                .clear_now(clear_vec[gi]),
                .pending(irq_pending_status[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // read data and interrupt pin
    // ------------------------------------------------------------------
    // byte mode returns the addressed half in the low byte with the upper byte zero
    wire [mic_pkg::MIC_HALF_W-1:0] status_lo = irq_pending_status[mic_pkg::MIC_HALF_W-1:0];
    wire [mic_pkg::MIC_HALF_W-1:0] status_hi =
        irq_pending_status[mic_pkg::MIC_DATA_W-1:mic_pkg::MIC_HALF_W];
    wire [mic_pkg::MIC_HALF_W-1:0] half_sel = hit_hi ? status_hi : status_lo;
    wire [15:0] rd_sel = bus_byte_mode ?
        {{mic_pkg::MIC_HALF_W{1'b0}}, half_sel} : irq_pending_status;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            host_rdata <= mic_pkg::MIC_STATUS_RST;
        end else if (rd_act && (hit_lo || hit_hi)) begin
            host_rdata <= rd_sel;
        end
    end
    // open-drain: output level is always low, enable drives it
    assign host_irq_out_n = 1'b0;
    assign host_irq_oe = |irq_pending_status;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    wire [15:0] gated_src = source_vec & irq_source_enable;
    wire [mic_pkg::MIC_HALF_W-1:0] enable_hi =
        irq_source_enable[mic_pkg::MIC_DATA_W-1:mic_pkg::MIC_HALF_W];

    irq_pin_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        host_irq_oe == (irq_pending_status != 16'h0000))
        else $error("interrupt pin disagrees with status");
    pin_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (host_irq_oe && !end_lo && !end_hi) |=> host_irq_oe)
        else $error("interrupt pin released without a status read");

    reset_mask_a: assert property (@(posedge core_clk)
        sys_rst |=> irq_source_enable == 16'h0000)
        else $error("enable not cleared by reset");
    enable_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !wr_act |=> $stable(irq_source_enable))
        else $error("enable changed without a write");
    enable_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (wr_lo && !bus_byte_mode) |=> irq_source_enable == $past(host_wdata))
        else $error("word write did not load the enable register");
    hi_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        wr_hi |=> enable_hi == $past(host_wdata[mic_pkg::MIC_HALF_W-1:0]))
        else $error("upper enable half not loaded");
    lo_keeps_hi_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (wr_lo && bus_byte_mode) |=> $stable(enable_hi))
        else $error("lower half write touched upper enable half");

    // clears land one edge after the read ends; a set in that edge wins
    half_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (bus_byte_mode && end_lo && !end_hi) |=> $stable(status_hi)
        || $past(|(gated_src[mic_pkg::MIC_DATA_W-1:mic_pkg::MIC_HALF_W])))
        else $error("low half read touched upper half");
    upper_keep_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (bus_byte_mode && end_hi && !end_lo) |=> $stable(status_lo)
        || $past(|(gated_src[mic_pkg::MIC_HALF_W-1:0])))
        else $error("upper half read touched lower half");
    word_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!bus_byte_mode && end_lo && gated_src == 16'h0000)
        |=> (irq_pending_status & $past(host_rdata)) == 16'h0000)
        else $error("reported status not cleared after read");
    keep_unread_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!bus_byte_mode && end_lo) |=>
        (~irq_pending_status & $past(irq_pending_status) & ~$past(host_rdata)) == 16'h0000)
        else $error("unreported status bit lost at read end");

    rdata_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(rd_act && (hit_lo || hit_hi)) |=> $stable(host_rdata))
        else $error("read data moved without a status read");
    upper_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (bus_byte_mode && rd_act && (hit_lo || hit_hi))
        |=> host_rdata[mic_pkg::MIC_DATA_W-1:mic_pkg::MIC_HALF_W] == 8'h00)
        else $error("byte read left data in the upper byte");
    split_edge_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (split_pulse_event && split_q && !irq_pending_status[mic_pkg::MIC_BIT_SPLIT])
        |=> !irq_pending_status[mic_pkg::MIC_BIT_SPLIT])
        else $error("split level re-set status");

    // ------------------------------------------------------------------
    // coverage
    // ------------------------------------------------------------------
    cov_word_read_c: cover property (@(posedge core_clk) end_lo && !bus_byte_mode);
    cov_multi_c: cover property (@(posedge core_clk) $countones(irq_pending_status) > 1);
    cov_byte_c: cover property (@(posedge core_clk) bus_byte_mode && end_hi);
    cov_kept_c: cover property (@(posedge core_clk)
        end_lo && |(irq_pending_status & ~host_rdata));
    cov_release_c: cover property (@(posedge core_clk) $fell(host_irq_oe));
endmodule // mic_irq_collector

/* test/mic_host_model.sv */
// host cpu model: drives the parallel register bus
`timescale 1ns/1ps
module mic_host_model (
    input wire logic core_clk,
    output logic [3:0] host_addr,
    output logic host_chip_sel_n,
    output logic host_read_strobe_n,
    output logic host_write_strobe_n,
    output logic [15:0] host_wdata,
    input wire logic [15:0] host_rdata
);
    initial begin
        host_addr = 4'hF;
        host_chip_sel_n = 1'b1;
        host_read_strobe_n = 1'b1;
        host_write_strobe_n = 1'b1;
        host_wdata = 16'h0000;
    end
    // in byte mode each enable half is its own write
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(negedge core_clk);
        {host_addr, host_wdata, host_chip_sel_n, host_write_strobe_n} = {a, d, 2'b00};
        @(negedge core_clk);
        {host_chip_sel_n, host_write_strobe_n} = 2'b11;
        host_wdata = ~d;
    endtask
    // address held for the whole strobe, so no stray status clear
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(negedge core_clk);
        {host_addr, host_chip_sel_n, host_read_strobe_n} = {a, 2'b00};
        repeat (2) @(negedge core_clk);
        d = host_rdata;
        {host_chip_sel_n, host_read_strobe_n} = 2'b11;
        repeat (3) @(negedge core_clk);
    endtask
endmodule // mic_host_model

/* test/mic_irq_collector_bench.sv */
// testbench: table-driven checks of the interrupt collector
`timescale 1ns/1ps
module mic_irq_collector_bench;
    typedef struct {logic [15:0] en; logic [15:0] ev; logic [15:0] exp;} mic_row_t;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic bus_byte_mode = 1'b0;
    logic [15:0] ev = 16'h0000;
    logic [3:0] host_addr;
    logic host_chip_sel_n, host_read_strobe_n, host_write_strobe_n;
    logic [15:0] host_wdata, host_rdata, rd_val;
    logic host_irq_out_n, host_irq_oe;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    // board pull-up on the shared open-drain line
    wire irq_pin = host_irq_oe ? host_irq_out_n : 1'b1;
    mic_row_t rows [4] = '{'{16'hFFFF, 16'hFFFF, 16'hFFFF}, '{16'h0000, 16'hFFFF, 16'h0000},
        '{16'hA5A5, 16'hFFFF, 16'hA5A5}, '{16'h5A5A, 16'h0F0F, 16'h0A0A}};
    always #50 core_clk = ~core_clk;
    mic_irq_collector dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .compare_hit(ev[3:0]),
        .drive_begin_event(ev[4]), .cruise_begin_event(ev[5]), .cruise_end_event(ev[6]),
        .drive_end_event(ev[7]), .home_end_event(ev[8]), .timer_expire_event(ev[9]),
        .split_pulse_event(ev[10]), .split_train_done_event(ev[11]),
        .linked_action_0_event(ev[12]), .linked_action_1_event(ev[13]),
        .linked_action_2_event(ev[14]), .linked_action_3_event(ev[15]),
        .bus_byte_mode(bus_byte_mode), .host_addr(host_addr), .host_chip_sel_n(host_chip_sel_n),
        .host_read_strobe_n(host_read_strobe_n), .host_write_strobe_n(host_write_strobe_n),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .host_irq_out_n(host_irq_out_n),
        .host_irq_oe(host_irq_oe));
    mic_host_model host_u (.core_clk(core_clk), .host_addr(host_addr),
        .host_chip_sel_n(host_chip_sel_n), .host_read_strobe_n(host_read_strobe_n),
        .host_write_strobe_n(host_write_strobe_n), .host_wdata(host_wdata),
        .host_rdata(host_rdata));
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one-cycle pulse on every source named in e
    task automatic fire(input logic [15:0] e);
        @(negedge core_clk);
        ev = e;
        @(negedge core_clk);
        ev = 16'h0000;
    endtask
    task automatic end_of_test;
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // whole run is under two hundred cycles; the ceiling only catches a hang
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_of_test;
        end
    end
    initial begin
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        fire(16'hFFFF);
        host_u.rd(mic_pkg::MIC_ADDR_STATUS, rd_val);
        chk("status_after_reset", rd_val, mic_pkg::MIC_STATUS_RST);
        foreach (rows[i]) begin
            host_u.wr(mic_pkg::MIC_ADDR_ENABLE, rows[i].en);
            fire(rows[i].ev);
            chk("pin", {15'h0, irq_pin}, {15'h0, rows[i].exp == 16'h0000});
            host_u.rd(mic_pkg::MIC_ADDR_STATUS, rd_val);
            chk("status", rd_val, rows[i].exp);
            chk("pin_released", {15'h0, irq_pin}, 16'h0001);
            host_u.rd(mic_pkg::MIC_ADDR_STATUS, rd_val);
            chk("status_reread", rd_val, 16'h0000);
        end
        host_u.wr(mic_pkg::MIC_ADDR_ENABLE, 16'h8001);
        fire(16'h0001);
        fire(16'h8000);
        host_u.rd(mic_pkg::MIC_ADDR_STATUS, rd_val);
        chk("two_events", rd_val, 16'h8001);
        // an event in the last strobe-low cycle misses the data and must stay pending
        fork
            host_u.rd(mic_pkg::MIC_ADDR_STATUS, rd_val);
            begin
                repeat (2) @(negedge core_clk);
                ev = 16'h8000;
                @(negedge core_clk);
                ev = 16'h0000;
            end
        join
        chk("mid_read_data", rd_val, 16'h0000);
        chk("mid_read_pin", {15'h0, irq_pin}, 16'h0000);
        host_u.rd(mic_pkg::MIC_ADDR_STATUS, rd_val);
        chk("mid_read_kept", rd_val, 16'h8000);
        bus_byte_mode = 1'b1;
        host_u.wr(mic_pkg::MIC_ADDR_ENABLE, 16'h0081);
        host_u.wr(mic_pkg::MIC_ADDR_ENABLE_HI, 16'h0024);
        fire(16'hFFFF);
        host_u.rd(mic_pkg::MIC_ADDR_STATUS_HI, rd_val);
        chk("upper_half", rd_val, 16'h0024);
        chk("pin_one_half", {15'h0, irq_pin}, 16'h0000);
        host_u.rd(mic_pkg::MIC_ADDR_STATUS, rd_val);
        chk("lower_half", rd_val, 16'h0081);
        chk("pin_both_halves", {15'h0, irq_pin}, 16'h0001);
        fire(16'h0001);
        host_u.rd(4'h5, rd_val);
        chk("unmapped_read", rd_val, 16'h0081);
        chk("pin_after_unmapped", {15'h0, irq_pin}, 16'h0000);
        host_u.wr(mic_pkg::MIC_ADDR_ENABLE_HI, 16'h0000);
        fire(16'hFFFF);
        host_u.rd(mic_pkg::MIC_ADDR_STATUS, rd_val);
        chk("lower_only", rd_val, 16'h0081);
        chk("pin_lower_only", {15'h0, irq_pin}, 16'h0001);
        // mid-run reset drops pending bits and masks every source again
        bus_byte_mode = 1'b0;
        host_u.wr(mic_pkg::MIC_ADDR_ENABLE, 16'hFFFF);
        fire(16'h0010);
        chk("pin_before_reset", {15'h0, irq_pin}, 16'h0000);
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        chk("pin_after_reset", {15'h0, irq_pin}, 16'h0001);
        host_u.wr(mic_pkg::MIC_ADDR_ENABLE_HI, 16'hFFFF);
        fire(16'hFFFF);
        chk("pin_masked_after_reset", {15'h0, irq_pin}, 16'h0001);
        host_u.rd(mic_pkg::MIC_ADDR_STATUS, rd_val);
        chk("status_masked", rd_val, 16'h0000);
        end_of_test;
    end
endmodule // mic_irq_collector_bench
